//--- design/dacr_pkg.sv
// Shared constants and types for the dual converter readout link.
// Assumes a 200 MHz controller clock and a serial clock made by the host.
package dacr_pkg;
   // ------------------------------------------------------------
   // Frame timing
   // ------------------------------------------------------------
   localparam int RES_W      = 12;
   localparam int FRAME_W    = 32;
   localparam int CNT_W      = 6;
   localparam int FALL_PD_LO = 2;
   localparam int FALL_PD_HI = 10;
   localparam int FALL_TRACK = 13;
   localparam int FALL_CONV  = 14;
   localparam int FALL_LAST  = 32;

   // ------------------------------------------------------------
   // Controller timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 5;
   localparam int QUIET_NS      = 30;
   localparam int QUIET_CYC     = (QUIET_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
   localparam int SCLK_HALF_CYC = 16;
   localparam int TMR_W         = 16;

   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [3:0] REG_CTRL   = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_RX_A   = 4'h8;
   localparam logic [3:0] REG_RX_B   = 4'hc;
   localparam int CTRL_START  = 0;
   localparam int CTRL_TYPE   = 1;
   localparam int CTRL_ADDR   = 2;
   localparam int CTRL_RANGE  = 5;
   localparam int CTRL_LEN    = 8;
   localparam int STAT_BUSY   = 0;
   localparam int STAT_DONE   = 1;
   localparam logic [5:0] LEN_RESET = 6'h20;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      DACR_NORMAL,
      DACR_PARTIAL_PD,
      DACR_FULL_PD
   } dacr_mode_t;
endpackage

//--- design/dacr_link_if.sv
// Serial link between the converter end and the host end.
// Assumes output lines read low while not driven.
interface dacr_link_if;
   logic       cs_n;
   logic       sclk;
   logic       input_type_select;
   logic [2:0] channel_address;
   logic       range_sel;
   logic       serial_out_a;
   logic       serial_out_a_oe;
   logic       serial_out_b;
   logic       serial_out_b_oe;
   logic       line_a;
   logic       line_b;

   assign line_a = serial_out_a_oe & serial_out_a;
   assign line_b = serial_out_b_oe & serial_out_b;

   modport device (
      input  cs_n, sclk, input_type_select, channel_address, range_sel,
      output serial_out_a, serial_out_a_oe, serial_out_b, serial_out_b_oe
   );
   modport host (
      output cs_n, sclk, input_type_select, channel_address, range_sel,
      input  line_a, line_b
   );
endinterface

//--- design/dacr_device.sv
// Converter end: input decode, framing, shift-out, power mode tracking.
// Assumes the host changes chip select only while the serial clock is high.
//
// Summary of operation
// - Twos complement unless single-ended reference range; code also gives straight binary for pseudo-differential with range low
// - Address and type pick inputs per converter
// - Select fall samples; serial clock drives conversion
// - Edge count at select rise picks mode
// - Host keeps select low ten edges
// - Rise in ten to fourteen aborts, floats
// - Full conversion needs fourteen serial clocks
// - Output held after fourteen until select rises
// - Two trailing zeros follow each result
// - Second result follows on line a
// - Float at edge thirty-two or select rise
// - Host raises select before next conversion
// - Host waits quiet interval before next frame
// - Type low pairs, high single-ended
// - Range low single span, high doubled
// - Track resumes at rising edge thirteen
// - Rise in two to ten powers down
module dacr_device
   import dacr_pkg::*;
(
   dacr_link_if.device        link,
   input  wire logic          rst_n,
   input  wire logic [11:0]   result_a,
   input  wire logic [11:0]   result_b,
   output dacr_mode_t         power_mode,
   output logic               tracking,
   output logic               sel_valid,
   output logic               sel_diff,
   output logic               sel_pseudo,
   output logic [2:0]         sel_pos,
   output logic [2:0]         sel_neg,
   output logic               coding_twos,
   output logic               last_aborted
);
   logic                active;
   logic [CNT_W-1:0]    edge_cnt;
   logic [FRAME_W-1:0]  shift_a;
   logic [FRAME_W-1:0]  shift_b;
   logic [FRAME_W-1:0]  word_a;
   logic [FRAME_W-1:0]  word_b;
   logic [RES_W-1:0]    code_a;
   logic [RES_W-1:0]    code_b;
   logic                twos_now;
   logic                start;

   // ------------------------------------------------------------
   // Coding and frame words
   // ------------------------------------------------------------
   function automatic logic twos_sel(input logic sgl, input logic a0,
                                     input logic rng);
      twos_sel = (!sgl && !a0) || rng;
   endfunction

   assign start    = !link.cs_n && !active;
   assign twos_now = twos_sel(link.input_type_select,
                              link.channel_address[0],
                              link.range_sel);
   assign code_a   = result_a ^ {twos_now, 11'h000};
   assign code_b   = result_b ^ {twos_now, 11'h000};
   assign word_a   = {2'b00, code_a, 2'b00, 2'b00, code_b, 2'b00};
   assign word_b   = {2'b00, code_b, 18'h00000};

   // ------------------------------------------------------------
   // Frame activity
   // ------------------------------------------------------------
   always_ff @(negedge link.sclk or posedge link.cs_n) begin
      if (link.cs_n) begin
         active <= 1'b0;
      end else if (!rst_n) begin
         active <= 1'b0;
      end else begin
         active <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Falling edge counter
   // ------------------------------------------------------------
   always_ff @(negedge link.sclk) begin
      if (!rst_n) begin
         edge_cnt <= '0;
      end else if (start) begin
         edge_cnt <= CNT_W'(1);
      end else if (!link.cs_n && edge_cnt != {CNT_W{1'b1}}) begin
         edge_cnt <= edge_cnt + CNT_W'(1);
      end
   end

   // ------------------------------------------------------------
   // Power mode
   // ------------------------------------------------------------
   always_ff @(negedge link.sclk) begin
      if (!rst_n) begin
         power_mode   <= DACR_NORMAL;
         last_aborted <= 1'b0;
      end else if (start) begin
         last_aborted <= edge_cnt >= CNT_W'(FALL_PD_HI)
                         && edge_cnt < CNT_W'(FALL_CONV);
         if (edge_cnt >= CNT_W'(FALL_PD_HI)) begin
            power_mode <= DACR_NORMAL;
         end else if (edge_cnt >= CNT_W'(FALL_PD_LO)) begin
            if (power_mode == DACR_NORMAL) begin
               power_mode <= DACR_PARTIAL_PD;
            end else begin
               power_mode <= DACR_FULL_PD;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Input selection
   // ------------------------------------------------------------
   always_ff @(negedge link.sclk) begin
      if (!rst_n) begin
         sel_valid   <= 1'b0;
         sel_diff    <= 1'b0;
         sel_pseudo  <= 1'b0;
         sel_pos     <= 3'h0;
         sel_neg     <= 3'h0;
         coding_twos <= 1'b0;
      end else if (start) begin
         coding_twos <= twos_now;
         if (link.input_type_select) begin
            sel_diff   <= 1'b0;
            sel_pseudo <= 1'b0;
            sel_valid  <= link.channel_address < 3'h6;
            sel_pos    <= link.channel_address + 3'h1;
            sel_neg    <= 3'h0;
         end else begin
            sel_diff   <= !link.channel_address[0];
            sel_pseudo <= link.channel_address[0];
            sel_valid  <= link.channel_address[2:1] != 2'b11;
            sel_pos    <= {link.channel_address[2:1], 1'b1};
            sel_neg    <= {link.channel_address[2:1], 1'b0} + 3'h2;
         end
      end
   end

   // ------------------------------------------------------------
   // Track-and-hold
   // ------------------------------------------------------------
   always_ff @(posedge link.sclk) begin
      if (!rst_n) begin
         tracking <= 1'b1;
      end else begin
         tracking <= !(active && !link.cs_n
                       && edge_cnt < CNT_W'(FALL_TRACK));
      end
   end

   // ------------------------------------------------------------
   // Shift-out of both lines
   // ------------------------------------------------------------
   always_ff @(negedge link.sclk) begin
      if (!rst_n) begin
         shift_a           <= '0;
         shift_b           <= '0;
         link.serial_out_a <= 1'b0;
         link.serial_out_b <= 1'b0;
      end else if (start) begin
         link.serial_out_a <= word_a[FRAME_W-1];
         link.serial_out_b <= word_b[FRAME_W-1];
         shift_a           <= {word_a[FRAME_W-2:0], 1'b0};
         shift_b           <= {word_b[FRAME_W-2:0], 1'b0};
      end else if (!link.cs_n) begin
         link.serial_out_a <= shift_a[FRAME_W-1];
         link.serial_out_b <= shift_b[FRAME_W-1];
         shift_a           <= {shift_a[FRAME_W-2:0], 1'b0};
         shift_b           <= {shift_b[FRAME_W-2:0], 1'b0};
      end
   end

   // ------------------------------------------------------------
   // Output enables
   // ------------------------------------------------------------
   always_ff @(negedge link.sclk or posedge link.cs_n) begin
      if (link.cs_n) begin
         link.serial_out_a_oe <= 1'b0;
         link.serial_out_b_oe <= 1'b0;
      end else if (!rst_n) begin
         link.serial_out_a_oe <= 1'b0;
         link.serial_out_b_oe <= 1'b0;
      end else if (start) begin
         link.serial_out_a_oe <= 1'b1;
         link.serial_out_b_oe <= 1'b1;
      end else if (edge_cnt == CNT_W'(FALL_LAST - 1)) begin
         link.serial_out_a_oe <= 1'b0;
         link.serial_out_b_oe <= 1'b0;
      end
   end
endmodule

//--- design/dacr_host.sv
// Host end: AXI4-Lite registers, serial clock divider, frame sequencing.
// Assumes aclk at 200 MHz and a device clocked from the serial clock.
//
// The AXI4-Lite register port and the register offsets are this design's own decisions.
module dacr_host
   import dacr_pkg::*;
#(
   parameter int HALF_CYC = SCLK_HALF_CYC
)
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [3:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [3:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   dacr_link_if.host        link
);
   typedef enum {H_IDLE, H_QUIET, H_RUN, H_END} dacr_hstate_t;

   if (HALF_CYC < 4 || HALF_CYC >= 2 ** TMR_W) begin : g_chk
      $error("HALF_CYC out of range");
   end

   localparam logic [TMR_W-1:0] HALF_M1  = TMR_W'(HALF_CYC - 1);
   localparam logic [TMR_W-1:0] QUIET_LD = TMR_W'(QUIET_CYC);

   dacr_hstate_t        state;
   logic [TMR_W-1:0]    tmr;
   logic [CNT_W-1:0]    falls;
   logic [CNT_W-1:0]    len;
   logic                type_q;
   logic [2:0]          addr_q;
   logic                range_q;
   logic                start_pend;
   logic                done;
   logic [31:0]         rx_a;
   logic [31:0]         rx_b;
   logic [1:0]          sync_a;
   logic [1:0]          sync_b;
   logic [3:0]          aw_addr;
   logic [31:0]         w_data;
   logic [3:0]          w_strb;
   logic                do_write;
   logic                start_wr;
   logic                sample;
   logic                frame_end;

   assign do_write  = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
   assign start_wr  = do_write && aw_addr == REG_CTRL && w_strb[0]
                      && w_data[CTRL_START];
   assign sample    = state == H_RUN && tmr == '0 && !link.sclk;
   assign frame_end = state == H_END && tmr == '0;

   // ------------------------------------------------------------
   // AXI4-Lite write channel
   // ------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
         aw_addr       <= 4'h0;
         w_data        <= 32'h0;
         w_strb        <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            aw_addr       <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            w_data       <= s_axi_wdata;
            w_strb       <= s_axi_wstrb;
         end
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr == REG_CTRL) ? RESP_OKAY : RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // Control register
   // ------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         type_q     <= 1'b0;
         addr_q     <= 3'h0;
         range_q    <= 1'b0;
         len        <= LEN_RESET;
         start_pend <= 1'b0;
         done       <= 1'b0;
      end else begin
         if (do_write && aw_addr == REG_CTRL) begin
            if (w_strb[0]) begin
               type_q  <= w_data[CTRL_TYPE];
               addr_q  <= w_data[CTRL_ADDR +: 3];
               range_q <= w_data[CTRL_RANGE];
            end
            if (w_strb[1]) begin
               len <= w_data[CTRL_LEN +: CNT_W];
            end
         end
         if (start_wr) begin
            start_pend <= 1'b1;
         end else if (state == H_IDLE) begin
            start_pend <= 1'b0;
         end
         if (frame_end) begin
            done <= 1'b1;
         end else if (start_wr) begin
            done <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // AXI4-Lite read channel
   // ------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0;
         s_axi_rresp   <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rresp   <= RESP_OKAY;
         if (s_axi_araddr == REG_CTRL) begin
            s_axi_rdata <= {18'h0, len, 2'b00, range_q, addr_q, type_q,
                            1'b0};
         end else if (s_axi_araddr == REG_STATUS) begin
            s_axi_rdata <= {30'h0, done, state != H_IDLE};
         end else if (s_axi_araddr == REG_RX_A) begin
            s_axi_rdata <= rx_a;
         end else if (s_axi_araddr == REG_RX_B) begin
            s_axi_rdata <= rx_b;
         end else begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_SLVERR;
         end
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Frame sequencer
   // ------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state                  <= H_IDLE;
         tmr                    <= '0;
         falls                  <= '0;
         link.cs_n              <= 1'b1;
         link.sclk              <= 1'b1;
         link.input_type_select <= 1'b0;
         link.channel_address   <= 3'h0;
         link.range_sel         <= 1'b0;
      end else begin
         case (state)
            H_IDLE: begin
               if (start_pend) begin
                  link.input_type_select <= type_q;
                  link.channel_address   <= addr_q;
                  link.range_sel         <= range_q;
                  tmr                    <= QUIET_LD;
                  state                  <= H_QUIET;
               end
            end
            H_QUIET: begin
               if (tmr == '0) begin
                  link.cs_n <= 1'b0;
                  falls     <= '0;
                  tmr       <= HALF_M1;
                  state     <= H_RUN;
               end else begin
                  tmr <= tmr - TMR_W'(1);
               end
            end
            H_RUN: begin
               if (tmr == '0) begin
                  tmr       <= HALF_M1;
                  link.sclk <= !link.sclk;
                  if (link.sclk) begin
                     falls <= falls + CNT_W'(1);
                  end else if (falls >= len) begin
                     state <= H_END;
                  end
               end else begin
                  tmr <= tmr - TMR_W'(1);
               end
            end
            H_END: begin
               if (tmr == '0) begin
                  link.cs_n <= 1'b1;
                  state     <= H_IDLE;
               end else begin
                  tmr <= tmr - TMR_W'(1);
               end
            end
            default: begin
               state <= H_IDLE;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Line receivers
   // ------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync_a <= 2'b00;
         sync_b <= 2'b00;
         rx_a   <= 32'h0;
         rx_b   <= 32'h0;
      end else begin
         sync_a <= {sync_a[0], link.line_a};
         sync_b <= {sync_b[0], link.line_b};
         if (sample) begin
            rx_a <= {rx_a[30:0], sync_a[1]};
            rx_b <= {rx_b[30:0], sync_b[1]};
         end
      end
   end
endmodule

//--- tb/dacr_checker.sv
// Link checker: framing, float and quiet timing.
// Assumes it sits beside the link interface in the bench top.
module dacr_checker
   import dacr_pkg::*;
(
   input wire logic       aclk,
   input wire logic       aresetn,
   input wire logic       rst_n,
   input wire logic       cs_n,
   input wire logic       sclk,
   input wire logic       input_type_select,
   input wire logic [2:0] channel_address,
   input wire logic       serial_out_a,
   input wire logic       serial_out_a_oe,
   input wire logic       serial_out_b,
   input wire logic       serial_out_b_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------------------------------------
   // Edge count
   // ------------------------------------------------------------
   logic [CNT_W-1:0] cnt;

   always_ff @(negedge sclk or posedge cs_n) begin
      if (cs_n) begin
         cnt <= '0;
      end else if (cnt != 6'h3f) begin
         cnt <= cnt + 6'h01;
      end
   end

   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   property p_drive_held;
      @(negedge sclk) disable iff (!rst_n)
      (cnt >= 6'h01 && cnt <= 6'h1f) |-> serial_out_a_oe && serial_out_b_oe;
   endproperty
   a_drive_held: assert property (p_drive_held)
      else $error("float in frame");

   property p_float_32;
      @(posedge aclk) disable iff (!aresetn)
      (!cs_n && cnt == 6'h20) |-> !serial_out_a_oe && !serial_out_b_oe;
   endproperty
   a_float_32: assert property (p_float_32)
      else $error("driven past 32");

   property p_float_idle;
      @(posedge aclk) disable iff (!aresetn)
      cs_n |-> !serial_out_a_oe && !serial_out_b_oe;
   endproperty
   a_float_idle: assert property (p_float_idle)
      else $error("driven while idle");

   property p_trail_zero;
      @(negedge sclk) disable iff (!rst_n)
      (cnt >= 6'h0f && cnt <= 6'h12) |-> !serial_out_a;
   endproperty
   a_trail_zero: assert property (p_trail_zero)
      else $error("a tail not zero");

   property p_b_tail;
      @(negedge sclk) disable iff (!rst_n)
      (cnt >= 6'h0f && cnt <= 6'h1f) |-> !serial_out_b;
   endproperty
   a_b_tail: assert property (p_b_tail)
      else $error("b tail not zero");

   property p_quiet;
      @(posedge aclk) disable iff (!aresetn)
      $rose(cs_n) |-> cs_n [*7];
   endproperty
   a_quiet: assert property (p_quiet)
      else $error("quiet too short");

   property p_sclk_idle;
      @(posedge aclk) disable iff (!aresetn)
      cs_n |-> sclk;
   endproperty
   a_sclk_idle: assert property (p_sclk_idle)
      else $error("sclk moved idle");

   property p_type_stable;
      @(posedge aclk) disable iff (!aresetn)
      (!cs_n && !$past(cs_n)) |->
         $stable(input_type_select) && $stable(channel_address);
   endproperty
   a_type_stable: assert property (p_type_stable)
      else $error("selection moved");
endmodule

//--- tb/dual_adc_conversion_readout_tb.sv
// Bench: host end and converter end joined over the link interface.
// Assumes the package, interface and both ends compile first.
module dual_adc_conversion_readout_tb
   import dacr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   logic        aclk = 1'b0, aresetn = 1'b0, rst_n = 1'b0;
   logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hf;
   logic [31:0] wdata = 32'h0, rdata, xa, xb;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic        arvalid = 1'b0, rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp;
   logic [11:0] res_a = 12'h000, res_b = 12'h000;
   dacr_mode_t  mode;
   logic        tracking, sel_valid, sel_diff, sel_pseudo;
   logic        coding_twos, last_aborted;
   logic [2:0]  sel_pos, sel_neg;
   int          err_count = 0, compares = 0;

   always #2.5 aclk = ~aclk;

   dacr_link_if dacr_link_if_i ();
   dacr_host dacr_host_i (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .link(dacr_link_if_i)
   );
   dacr_device dacr_device_i (
      .link(dacr_link_if_i), .rst_n(rst_n), .result_a(res_a),
      .result_b(res_b), .power_mode(mode), .tracking(tracking),
      .sel_valid(sel_valid), .sel_diff(sel_diff), .sel_pseudo(sel_pseudo),
      .sel_pos(sel_pos), .sel_neg(sel_neg), .coding_twos(coding_twos),
      .last_aborted(last_aborted)
   );
   dacr_checker dacr_checker_i (
      .aclk(aclk), .aresetn(aresetn), .rst_n(rst_n),
      .cs_n(dacr_link_if_i.cs_n), .sclk(dacr_link_if_i.sclk),
      .input_type_select(dacr_link_if_i.input_type_select),
      .channel_address(dacr_link_if_i.channel_address),
      .serial_out_a(dacr_link_if_i.serial_out_a),
      .serial_out_a_oe(dacr_link_if_i.serial_out_a_oe),
      .serial_out_b(dacr_link_if_i.serial_out_b),
      .serial_out_b_oe(dacr_link_if_i.serial_out_b_oe)
   );

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic chk(input string n, input logic [31:0] e,
                      input logic [31:0] g);
      compares++;
      if (g !== e) begin
         err_count++;
         $display("MISMATCH %s exp %h got %h", n, e, g);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d,
                     output logic [1:0] r);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while ((awvalid && !awready) || (wvalid && !wready));
      do @(posedge aclk); while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, output logic [31:0] d,
                     output logic [1:0] r);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask

   task automatic frame(input logic t, input logic [2:0] a, input logic r,
                        input logic [5:0] n, output logic [31:0] ra,
                        output logic [31:0] rb);
      logic [31:0] s;
      logic [1:0]  p;
      wr(4'h0, {18'h0, n, 2'b00, r, a, t, 1'b1}, p);
      do rd(4'h4, s, p); while (s[1] !== 1'b1);
      chk("stat", 32'h2, s);
      rd(4'h8, ra, p);
      rd(4'hc, rb, p);
   endtask

   task automatic wrap_up;
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_regs;
      logic [31:0] d;
      logic [1:0]  r;
      rd(4'h0, d, r);
      chk("ctrl", 32'h0000_2000, d);
      wr(4'h8, 32'h0000_0001, r);
      chk("ro", {30'h0, RESP_SLVERR}, {30'h0, r});
      rd(4'h2, d, r);
      chk("unmap", {30'h0, RESP_SLVERR}, {30'h0, r});
      chk("unmap_d", 32'h0, d);
   endtask

   task automatic t_decode;
      logic        t, r, tw;
      logic [2:0]  a, ep, en;
      logic [11:0] ca, cb;
      for (int i = 0; i < 13; i++) begin
         t = (i < 7);
         a = t ? i[2:0] : 3'(i - 7);
         r = (i == 5 || i == 10 || i == 12);
         res_a <= 12'h5a3 + 12'(i);
         res_b <= 12'h1c6 ^ 12'(i);
         frame(t, a, r, 6'h20, xa, xb);
         tw = r | (!t & !a[0]);
         ca = (12'h5a3 + 12'(i)) ^ {tw, 11'h000};
         cb = (12'h1c6 ^ 12'(i)) ^ {tw, 11'h000};
         ep = t ? a + 3'h1 : {a[2:1], 1'b1};
         en = t ? 3'h0 : {a[2:1], 1'b1} + 3'h1;
         chk("rx_a", {2'b0, ca, 4'h0, cb, 2'b0}, xa);
         chk("rx_b", {2'b0, cb, 18'h0}, xb);
         chk("twos", {31'h0, tw}, {31'h0, coding_twos});
         chk("valid", {31'h0, !t | (a < 3'h6)}, {31'h0, sel_valid});
         if (!t || a < 3'h6) begin
            chk("pos", {29'h0, ep}, {29'h0, sel_pos});
            chk("neg", {29'h0, en}, {29'h0, sel_neg});
            chk("kind", {30'h0, !t & !a[0], !t & a[0]},
                {30'h0, sel_diff, sel_pseudo});
         end
      end
   endtask

   task automatic t_power;
      logic [5:0] len [6] = '{6'h0c, 6'h05, 6'h05, 6'h01, 6'h10, 6'h20};
      dacr_mode_t md [6] = '{DACR_NORMAL, DACR_NORMAL, DACR_PARTIAL_PD,
                             DACR_FULL_PD, DACR_FULL_PD, DACR_NORMAL};
      logic [5:0] ab = 6'h02;
      res_a <= 12'h3c5;
      for (int i = 0; i < 6; i++) begin
         frame(1'b1, 3'h0, 1'b0, len[i], xa, xb);
         chk("mode", {30'h0, md[i]}, {30'h0, mode});
         chk("abort", {31'h0, ab[i]}, {31'h0, last_aborted});
         chk("track", {31'h0, len[i] >= 6'(FALL_TRACK)},
             {31'h0, tracking});
         if (i == 4) begin
            chk("rx16", {18'h0, 12'h3c5, 2'b0}, {16'h0, xa[15:0]});
         end
      end
   endtask

   initial begin
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs;
      frame(1'b1, 3'h0, 1'b0, 6'h20, xa, xb);
      rst_n <= 1'b1;
      t_decode;
      t_power;
      wrap_up;
   end

   initial begin
      repeat (60000) @(posedge aclk);
      err_count++;
      wrap_up;
   end
endmodule
